// ===== pkg/envdsc_pkg.sv
// package for the emulated nonvolatile data store controller
// assumes a 10 MHz system clock and an APB register bus
package envdsc_pkg;

    // clock and timing
    localparam int CLK_HZ       = 10_000_000;
    localparam int PROG_T_MS    = 2;
    localparam int PROG_BASE_CYC = (CLK_HZ / 1000) * PROG_T_MS;
    localparam int READ_CYC     = 2;
    localparam int TIMER_W      = 18;

    // store geometry
    localparam int NV_WORDS     = 32;
    localparam int NV_WIDTH     = 16;
    localparam int NV_AW        = 5;
    localparam int STAGE_WORDS  = 4;

    // register byte offsets
    localparam logic [7:0] OFF_ADDRESS = 8'h00;
    localparam logic [7:0] OFF_W0_LOW  = 8'h04;
    localparam logic [7:0] OFF_STEP    = 8'h08;
    localparam logic [7:0] OFF_HI_GAP  = 8'h04;
    localparam logic [7:0] OFF_CONTROL = 8'h24;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h28;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h2C;

    // control register fields
    localparam int CTL_TSEL_LSB = 6;
    localparam int CTL_ER_EN    = 5;
    localparam int CTL_ER_GO    = 4;
    localparam int CTL_WR_EN    = 3;
    localparam int CTL_WR_GO    = 2;
    localparam int CTL_RD_EN    = 1;
    localparam int CTL_RD_GO    = 0;

    // interrupt status fields
    localparam int IRQ_ERASE_DONE = 0;
    localparam int IRQ_WRITE_DONE = 1;
    localparam int IRQ_READ_DONE  = 2;
    localparam int IRQ_START_LOST = 3;
    localparam int IRQ_W          = 4;

    // reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [15:0] ERASED    = 16'h0000;

endpackage

// ===== verilog/envdsc_top.sv
// emulated nonvolatile data store: 32 x 16 store, APB registers, op timer
// assumes an APB master on the same clock and that the CPU honours halt
//
// Operation
// - store holds 32 words of 16 bits
// - erase clears 16-word page by bit 4
// - write programs 4-word unit by bits 4..2
// - read fetches one word at full address
// - four staging words, byte halves, reset zero
// - time select gives 2, 4, 8, 16 ms
// - erase enable gates erase, auto clears
// - erase start runs erase, clears at end
// - erase start ignored without prior enable
// - write enable gates write, auto clears
// - write start needs prior enable, clears at end
// - read enable gates read, never auto clears
// - read start needs prior enable, clears at end
// - erase and write start must follow enable write immediately
// - erased page reads back all zeros
// - read result lands in first staging word
// - CPU halted while an operation runs
`timescale 1ns/1ps
module envdsc_top
    import envdsc_pkg::*;
#(
    parameter int PROG_CYC = PROG_BASE_CYC
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             cpu_halt,
    output logic             irq
);

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ERASE = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_READ  = 4'b1000
    } envdsc_state_t;

    ////////////////////////////////////////////////////////////////////////
    // state
    envdsc_state_t           state;
    logic [TIMER_W-1:0]      timer;
    logic [NV_WIDTH-1:0]     mem [NV_WORDS];
    logic [NV_WIDTH-1:0]     stage [STAGE_WORDS];
    logic [NV_AW-1:0]        nv_address;
    logic [1:0]              time_sel;
    logic                    erase_enable;
    logic                    erase_start;
    logic                    write_enable;
    logic                    write_start;
    logic                    read_enable;
    logic                    read_start;
    logic                    fresh_erase;
    logic                    fresh_write;
    logic [IRQ_W-1:0]        irq_status;
    logic [IRQ_W-1:0]        irq_mask;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire apb_done  = psel && penable && pready;
    wire apb_wr    = apb_done && pwrite;
    wire apb_rd    = apb_done && !pwrite;
    wire hit_addr  = paddr == OFF_ADDRESS;
    wire hit_ctl   = paddr == OFF_CONTROL;
    wire hit_ist   = paddr == OFF_IRQ_ST;
    wire hit_imsk  = paddr == OFF_IRQ_MSK;
    wire wr_ctl    = apb_wr && hit_ctl;
    wire busy      = state != ST_IDLE;
    wire finishing = busy && timer == TIMER_W'(1);

    function automatic logic hit_stage(input logic [7:0] a,
                                       input int n,
                                       input logic hi);
        logic [7:0] base;
        base = OFF_W0_LOW + 8'(n) * OFF_STEP;
        hit_stage = a == (hi ? base + OFF_HI_GAP : base);
    endfunction

    logic [STAGE_WORDS-1:0] hit_lo;
    logic [STAGE_WORDS-1:0] hit_hi;
    for (genvar n = 0; n < STAGE_WORDS; n++) begin : g_hit
        assign hit_lo[n] = hit_stage(paddr, n, 1'b0);
        assign hit_hi[n] = hit_stage(paddr, n, 1'b1);
    end
    wire hit_any = hit_addr || hit_ctl || hit_ist || hit_imsk
                   || (|hit_lo) || (|hit_hi);

    ////////////////////////////////////////////////////////////////////////
    // start acceptance
    wire go_er   = pwdata[CTL_ER_GO] && pwdata[CTL_ER_EN];
    wire go_wr   = pwdata[CTL_WR_GO] && pwdata[CTL_WR_EN];
    wire go_rd   = pwdata[CTL_RD_GO] && pwdata[CTL_RD_EN];
    wire accept_erase = wr_ctl && go_er && erase_enable && fresh_erase;
    wire accept_write = wr_ctl && go_wr && write_enable && fresh_write
                        && !accept_erase;
    wire accept_read  = wr_ctl && go_rd && read_enable
                        && !accept_erase && !accept_write;
    wire accept_any   = accept_erase || accept_write || accept_read;
    wire start_lost   = wr_ctl && !accept_any
                        && (pwdata[CTL_ER_GO] || pwdata[CTL_WR_GO]
                            || pwdata[CTL_RD_GO]);

    wire [TIMER_W-1:0] prog_dur = TIMER_W'(PROG_CYC) << time_sel;
    wire [TIMER_W-1:0] read_dur = TIMER_W'(READ_CYC);

    ////////////////////////////////////////////////////////////////////////
    // read mux
    wire [7:0] ctl_value = {time_sel, erase_enable, erase_start,
                            write_enable, write_start,
                            read_enable, read_start};
    logic [7:0] stage_value;
    always_comb begin
        stage_value = RST_BYTE;
        for (int n = 0; n < STAGE_WORDS; n++) begin
            if (hit_lo[n]) begin
                stage_value = stage[n][7:0];
            end
            if (hit_hi[n]) begin
                stage_value = stage[n][15:8];
            end
        end
    end
    wire [7:0] rd_value = hit_addr ? {3'h0, nv_address} :
                          hit_ctl  ? ctl_value :
                          hit_ist  ? {4'h0, irq_status} :
                          hit_imsk ? {4'h0, irq_mask} : stage_value;

    // access phase stalls while an operation runs
    wire next_pready = psel && !pready && !busy;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= next_pready ? {24'h00_0000, rd_value} : 32'h0000_0000;
            pslverr <= next_pready && !hit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            nv_address   <= 5'h00;
            time_sel     <= 2'h0;
            erase_enable <= 1'b0;
            erase_start  <= 1'b0;
            write_enable <= 1'b0;
            write_start  <= 1'b0;
            read_enable  <= 1'b0;
            read_start   <= 1'b0;
        end else if (wr_ctl) begin
            time_sel     <= pwdata[CTL_TSEL_LSB +: 2];
            erase_enable <= pwdata[CTL_ER_EN];
            write_enable <= pwdata[CTL_WR_EN];
            read_enable  <= pwdata[CTL_RD_EN];
            erase_start  <= accept_erase;
            write_start  <= accept_write;
            read_start   <= accept_read;
        end else if (finishing) begin
            case (state)
                ST_ERASE: begin
                    erase_enable <= 1'b0;
                    erase_start  <= 1'b0;
                end
                ST_WRITE: begin
                    write_enable <= 1'b0;
                    write_start  <= 1'b0;
                end
                ST_READ: begin
                    read_start   <= 1'b0;
                end
                default: begin
                    read_start   <= read_start;
                end
            endcase
        end else if (apb_wr && hit_addr) begin
            nv_address   <= pwdata[NV_AW-1:0];
        end
    end

    // enable set by the previous transfer, any other transfer stales it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fresh_erase <= 1'b0;
            fresh_write <= 1'b0;
        end else if (apb_done) begin
            fresh_erase <= wr_ctl && pwdata[CTL_ER_EN]
                           && !pwdata[CTL_ER_GO] && !erase_enable;
            fresh_write <= wr_ctl && pwdata[CTL_WR_EN]
                           && !pwdata[CTL_WR_GO] && !write_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operation sequencer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            timer <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (accept_erase) begin
                        state <= ST_ERASE;
                        timer <= prog_dur;
                    end else if (accept_write) begin
                        state <= ST_WRITE;
                        timer <= prog_dur;
                    end else if (accept_read) begin
                        state <= ST_READ;
                        timer <= read_dur;
                    end
                end
                ST_ERASE, ST_WRITE, ST_READ: begin
                    timer <= timer - TIMER_W'(1);
                    if (finishing) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cpu_halt <= 1'b0;
        end else begin
            cpu_halt <= accept_any || (busy && !finishing);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // store array, kept across reset
    always_ff @(posedge clock) begin
        if (finishing && state == ST_ERASE) begin
            for (int i = 0; i < NV_WORDS / 2; i++) begin
                mem[{nv_address[4], 4'(i)}] <= ERASED;
            end
        end else if (finishing && state == ST_WRITE) begin
            for (int n = 0; n < STAGE_WORDS; n++) begin
                mem[{nv_address[4:2], 2'(n)}] <= stage[n];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // staging words
    wire [NV_WIDTH-1:0] fetched = mem[nv_address];
    for (genvar n = 0; n < STAGE_WORDS; n++) begin : g_stage
        wire read_load = (n == 0) && finishing && state == ST_READ;
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                stage[n] <= RST_WORD;
            end else if (read_load) begin
                stage[n] <= fetched;
            end else if (apb_wr && hit_lo[n]) begin
                stage[n][7:0] <= pwdata[7:0];
            end else if (apb_wr && hit_hi[n]) begin
                stage[n][15:8] <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: set wins over read clear
    wire [IRQ_W-1:0] irq_set = {start_lost,
                                finishing && state == ST_READ,
                                finishing && state == ST_WRITE,
                                finishing && state == ST_ERASE};
    wire [IRQ_W-1:0] next_irq_status =
        ((apb_rd && hit_ist) ? '0 : irq_status) | irq_set;
    wire [IRQ_W-1:0] next_irq_mask =
        (apb_wr && hit_imsk) ? pwdata[IRQ_W-1:0] : irq_mask;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_status <= '0;
            irq_mask   <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            irq        <= |(next_irq_status & next_irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_erase_gate_off:
    assert property (@(posedge clock) disable iff (!nrst)
        wr_ctl && pwdata[CTL_ER_GO] && !erase_enable
        |=> !erase_start && state != ST_ERASE)
        else $error("erase started without prior enable");

    a_erase_pair_fresh:
    assert property (@(posedge clock) disable iff (!nrst)
        wr_ctl && go_er && !fresh_erase |=> state != ST_ERASE)
        else $error("erase accepted without consecutive enable");

    a_write_gate_off:
    assert property (@(posedge clock) disable iff (!nrst)
        wr_ctl && pwdata[CTL_WR_GO] && !write_enable
        |=> !write_start && state != ST_WRITE)
        else $error("write started without prior enable");

    a_erase_end_clears:
    assert property (@(posedge clock) disable iff (!nrst)
        finishing && state == ST_ERASE
        |=> !erase_enable && !erase_start && state == ST_IDLE)
        else $error("erase end did not clear control bits");

    a_write_end_clears:
    assert property (@(posedge clock) disable iff (!nrst)
        finishing && state == ST_WRITE |=> !write_enable && !write_start)
        else $error("write end did not clear control bits");

    a_read_keeps_en:
    assert property (@(posedge clock) disable iff (!nrst)
        finishing && state == ST_READ
        |=> read_enable == $past(read_enable) && !read_start)
        else $error("read end handled enable or start wrongly");

    a_prog_time_sel:
    assert property (@(posedge clock) disable iff (!nrst)
        accept_erase || accept_write
        |=> timer == TIMER_W'(PROG_CYC) << $past(time_sel))
        else $error("program time does not follow selection");

    a_read_result_word:
    assert property (@(posedge clock) disable iff (!nrst)
        finishing && state == ST_READ |=> stage[0] == $past(fetched))
        else $error("read word not placed in first staging word");

    a_erase_page_zero:
    assert property (@(posedge clock) disable iff (!nrst)
        finishing && state == ST_ERASE
        |=> mem[{nv_address[4], 4'h0}] == ERASED
            && mem[{nv_address[4], 4'hF}] == ERASED)
        else $error("erased page not all zero");

    a_write_unit_map:
    assert property (@(posedge clock) disable iff (!nrst)
        finishing && state == ST_WRITE
        |=> mem[{nv_address[4:2], 2'h3}] == $past(stage[3]))
        else $error("staging word not at unit address");

    a_halt_while_busy:
    assert property (@(posedge clock) disable iff (!nrst)
        busy |-> cpu_halt && !pready)
        else $error("cpu not halted during operation");

endmodule

// ===== bench/envdsc_top_tb.sv
// self-checking bench for the nonvolatile data store controller
// assumes envdsc_pkg and envdsc_top; drives APB, checks reads in a monitor
`timescale 1ns/1ps
module envdsc_top_tb;
    import envdsc_pkg::*;
    localparam int PC = 8;
    logic        clock;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cpu_halt;
    logic        irq;
    int          error_cnt;
    int          total_checks;
    int          halt_cnt;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [15:0] mem [NV_WORDS];
    logic [15:0] stg [STAGE_WORDS];
    localparam logic [32:0] ERRB = 33'h1_0000_0000;

    envdsc_top #(.PROG_CYC(PC)) i_dut (.clock(clock), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_halt(cpu_halt), .irq(irq));

    initial clock = 1'b0;
    always #50 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // monitor: one note per completed transfer, taken at the ready edge
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            chk({pslverr, prdata} & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    always @(negedge clock) if (cpu_halt === 1'b1) halt_cnt++;

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        logic [31:0] r;
        r = $urandom();
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {r[31:8], d};
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h0, ERRB);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        apb(1'b0, a, 8'h00, {25'h0, d}, {33{1'b1}});
    endtask

    task automatic erase(input logic [4:0] a, input logic [1:0] ts);
        wr(OFF_ADDRESS, {3'h0, a});
        wr(OFF_CONTROL, {ts, 6'h20});
        wr(OFF_CONTROL, {ts, 6'h30});
        halt_cnt = 0;
        rd(OFF_CONTROL, {ts, 6'h00});
        chk(33'(halt_cnt), 33'(PC << ts));
        rd(OFF_IRQ_ST, 8'h01);
        for (int i = 0; i < 16; i++) mem[{a[4], 4'(i)}] = ERASED;
    endtask

    task automatic prog(input logic [4:0] a, input logic [1:0] ts);
        for (int n = 0; n < STAGE_WORDS; n++) begin
            stg[n] = 16'($urandom());
            wr(OFF_W0_LOW + 8'(8 * n), stg[n][7:0]);
            wr(OFF_W0_LOW + 8'(8 * n + 4), stg[n][15:8]);
        end
        wr(OFF_ADDRESS, {3'h0, a});
        wr(OFF_CONTROL, {ts, 6'h08});
        wr(OFF_CONTROL, {ts, 6'h0C});
        halt_cnt = 0;
        rd(OFF_CONTROL, {ts, 6'h00});
        chk(33'(halt_cnt), 33'(PC << ts));
        rd(OFF_IRQ_ST, 8'h02);
        for (int n = 0; n < 4; n++) mem[{a[4:2], 2'(n)}] = stg[n];
    endtask

    task automatic fetch(input logic [4:0] a);
        wr(OFF_ADDRESS, {3'h0, a});
        wr(OFF_CONTROL, 8'h03);
        halt_cnt = 0;
        rd(OFF_CONTROL, 8'h02);
        chk(33'(halt_cnt), 33'(READ_CYC));
        rd(OFF_W0_LOW, mem[a][7:0]);
        rd(OFF_W0_LOW + 8'h04, mem[a][15:8]);
        rd(OFF_IRQ_ST, 8'h04);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        error_cnt = 0;
        total_checks = 0;
        halt_cnt = 0;
        void'($urandom(2));
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        for (int a = 0; a <= 8'h2C; a += 4) rd(8'(a), RST_BYTE);
        for (int i = 1; i <= 8; i++) begin
            d = 8'($urandom());
            wr(8'(4 * i), d);
            rd(8'(4 * i), d);
        end
        apb(1'b0, 8'h30, 8'h00, ERRB, {33{1'b1}});
        apb(1'b1, 8'h3C, 8'h5A, ERRB, ERRB);
        for (int t = 0; t < 4; t++) erase(5'(t * 8 + 3), 2'(t));
        prog({3'd1, 2'($urandom())}, 2'($urandom()));
        prog({3'd5, 2'($urandom())}, 2'($urandom()));
        erase({1'b1, 4'($urandom())}, 2'b00);
        wr(OFF_CONTROL, 8'h02);
        for (int i = 4; i < 8; i++) fetch(5'(i));
        for (int i = 20; i < 24; i++) fetch(5'(i));
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_IRQ_MSK, 8'h08);
        halt_cnt = 0;
        wr(OFF_CONTROL, 8'h10);
        rd(OFF_CONTROL, 8'h00);
        wr(OFF_CONTROL, 8'h04);
        rd(OFF_CONTROL, 8'h00);
        wr(OFF_CONTROL, 8'h01);
        rd(OFF_CONTROL, 8'h00);
        wr(OFF_CONTROL, 8'h20);
        wr(OFF_ADDRESS, 8'h00);
        wr(OFF_CONTROL, 8'h30);
        rd(OFF_CONTROL, 8'h20);
        chk(33'(halt_cnt), 33'h0);
        repeat (2) @(negedge clock);
        chk({32'h0, irq}, 33'h1);
        rd(OFF_IRQ_ST, 8'h08);
        repeat (2) @(negedge clock);
        chk({32'h0, irq}, 33'h0);
        wr(OFF_CONTROL, 8'h00);
        repeat (4) @(posedge clock);
        finish_test();
    end
endmodule
